// [core/pfl_consts.vh]
// Command codes, reset values, field positions and timing for the fault limit block
`ifndef PFL_CONSTS_VH
`define PFL_CONSTS_VH

`define PFL_CMD_UV_LIMIT 8'h44
`define PFL_CMD_UV_REACTION 8'h45
`define PFL_CMD_OC_LIMIT 8'h46
`define PFL_CMD_UC_LIMIT 8'h4B
`define PFL_CMD_OT_LIMIT 8'h4F

`define PFL_RST_UV_LIMIT 16'h0000
`define PFL_RST_UV_REACTION 8'h00
`define PFL_RST_OC_LIMIT 16'h0000
`define PFL_RST_UC_LIMIT 16'h0000
`define PFL_RST_OT_LIMIT 16'h0000

`define PFL_MODE_MSB 7
`define PFL_MODE_LSB 6
`define PFL_RETRY_MSB 5
`define PFL_RETRY_LSB 3
`define PFL_DELAY_MSB 2
`define PFL_DELAY_LSB 0
`define PFL_MODE_DISABLE_RETRY 2'h2
`define PFL_RETRY_NONE 3'h0
`define PFL_RETRY_ENDLESS 3'h7

`define PFL_CLK_HZ 100000000
`define PFL_RETRY_UNIT_MS 35
`define PFL_RETRY_UNIT_CYCLES (`PFL_RETRY_UNIT_MS * (`PFL_CLK_HZ / 1000))

`endif

// [core/pfl_retry_timer.v]
// Restart delay timer: waits (steps + 1) units after a start pulse
`include "pfl_consts.vh"
`default_nettype none

module pfl_retry_timer #(
  parameter UNIT_CYCLES = `PFL_RETRY_UNIT_CYCLES,
  parameter CW = 22
) (
  input wire clk_sys,
  input wire rst_n,
  input wire start,
  input wire cancel,
  input wire [2:0] steps,
  output reg done_q
);

  reg [CW-1:0] unit_cnt_q;
  reg [2:0] step_cnt_q;
  reg busy_q;
  wire unit_end = (unit_cnt_q == UNIT_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_q <= {CW{1'b0}};
      step_cnt_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cancel) begin
        busy_q <= 1'b0;
        unit_cnt_q <= {CW{1'b0}};
      end else if (start) begin
        busy_q <= 1'b1;
        unit_cnt_q <= {CW{1'b0}};
        step_cnt_q <= steps;
      end else if (busy_q) begin
        if (unit_end) begin
          unit_cnt_q <= {CW{1'b0}};
          if (step_cnt_q == 3'h0) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            step_cnt_q <= step_cnt_q - 3'h1;
          end
        end else begin
          unit_cnt_q <= unit_cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // pfl_retry_timer

`default_nettype wire

// [core/pfl_fault_ctrl.v]
// Fault threshold registers, fault detection and under-voltage restart control
//
// What this block does
// - Word register 0x44 holds under-voltage threshold.
// - Same threshold also drops the output-good flag.
// - Byte register 0x45 selects under-voltage reaction.
// - Every mode pulls alert low, sets fault flag.
// - Mode 10 disables output at once, then retries.
// - Restart count comes from bits 5:3.
// - Count 000: no restart, stay off until cleared.
// - Count 111: retry endlessly until off or shutdown.
// - Delay between restarts is (bits 2:0 + 1) x 35 ms.
// - Per-phase over-current peak limit at 0x46, Linear.
// - Per-phase under-current peak limit at 0x4B, Linear.
// - Over-temperature limit at 0x4F, Linear format.
// - Voltage thresholds compare as plain unsigned numbers.
`include "pfl_consts.vh"
`default_nettype none

module pfl_fault_ctrl #(
  parameter RETRY_UNIT_CYCLES = `PFL_RETRY_UNIT_CYCLES
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] cmd_code,
  input wire cmd_write,
  input wire cmd_read,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata_q,
  output reg cmd_rvalid_q,
  output reg cmd_unsupported_q,
  input wire output_on_cmd,
  input wire bias_ok,
  input wire clear_faults,
  input wire [15:0] vout_meas,
  input wire [15:0] iout_phase0_peak,
  input wire [15:0] iout_phase1_peak,
  input wire [15:0] temp_meas,
  output reg output_enable_q,
  output reg output_good_flag_q,
  output reg fault_uv_q,
  output reg fault_oc_q,
  output reg fault_uc_q,
  output reg fault_ot_q,
  output wire alert_line_out,
  output wire alert_line_oe_n
);

  localparam ST_OFF = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [15:0] uv_limit_q;
  reg [7:0] uv_reaction_q;
  reg [15:0] oc_limit_q;
  reg [15:0] uc_limit_q;
  reg [15:0] ot_limit_q;
  reg [3:0] state_q;
  reg [2:0] retries_q;
  reg armed_q;

  // Linear word to signed fixed point scaled by 2^16, so exponents compare fairly
  function signed [47:0] lin_to_fix;
    input [15:0] w;
    reg [4:0] sh;
    begin
      sh = w[15:11] + 5'h10;
      lin_to_fix = {{37{w[10]}}, w[10:0]} <<< sh;
    end
  endfunction

  function known_cmd;
    input [7:0] c;
    begin
      known_cmd = (c == `PFL_CMD_UV_LIMIT) || (c == `PFL_CMD_UV_REACTION) ||
        (c == `PFL_CMD_OC_LIMIT) || (c == `PFL_CMD_UC_LIMIT) || (c == `PFL_CMD_OT_LIMIT);
    end
  endfunction

  wire [1:0] uv_mode = uv_reaction_q[`PFL_MODE_MSB:`PFL_MODE_LSB];
  wire [2:0] retry_field = uv_reaction_q[`PFL_RETRY_MSB:`PFL_RETRY_LSB];
  wire [2:0] delay_field = uv_reaction_q[`PFL_DELAY_MSB:`PFL_DELAY_LSB];

  // Output voltage is an unsigned mode word, not Linear
  wire vout_low = (vout_meas < uv_limit_q);
  wire uv_ev = (state_q == ST_RUN) && vout_low;
  wire signed [47:0] oc_fix = lin_to_fix(oc_limit_q);
  wire signed [47:0] uc_fix = lin_to_fix(uc_limit_q);
  // Each phase is checked against the per-phase value on its own
  wire oc_ev = (lin_to_fix(iout_phase0_peak) > oc_fix) ||
    (lin_to_fix(iout_phase1_peak) > oc_fix);
  wire uc_ev = (lin_to_fix(iout_phase0_peak) < uc_fix) ||
    (lin_to_fix(iout_phase1_peak) < uc_fix);
  wire ot_ev = lin_to_fix(temp_meas) > lin_to_fix(ot_limit_q);
  wire shutdown_ev = oc_ev || ot_ev;
  wire go_off = !output_on_cmd || !bias_ok;
  wire uv_retry_mode = (uv_mode == `PFL_MODE_DISABLE_RETRY);
  // First fault of a sequence takes the programmed count, later ones the remainder
  wire [2:0] retries_now = armed_q ? retries_q : retry_field;
  wire start_wait = (state_q == ST_RUN) && !go_off && !shutdown_ev && uv_ev &&
    uv_retry_mode && (retries_now != `PFL_RETRY_NONE);
  wire tmr_done;

  pfl_retry_timer #(
    .UNIT_CYCLES(RETRY_UNIT_CYCLES),
    .CW(32)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(start_wait),
    .cancel(state_q != ST_WAIT && !start_wait),
    .steps(delay_field),
    .done_q(tmr_done)
  );

  // Open drain: pulled low while any fault flag stands
  assign alert_line_out = 1'b0;
  assign alert_line_oe_n = !(fault_uv_q || fault_oc_q || fault_uc_q || fault_ot_q);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uv_limit_q <= `PFL_RST_UV_LIMIT;
      uv_reaction_q <= `PFL_RST_UV_REACTION;
      oc_limit_q <= `PFL_RST_OC_LIMIT;
      uc_limit_q <= `PFL_RST_UC_LIMIT;
      ot_limit_q <= `PFL_RST_OT_LIMIT;
      cmd_rdata_q <= 16'h0000;
      cmd_rvalid_q <= 1'b0;
      cmd_unsupported_q <= 1'b0;
    end else begin
      cmd_rvalid_q <= cmd_read;
      cmd_unsupported_q <= (cmd_read || cmd_write) && !known_cmd(cmd_code);
      if (cmd_write) begin
        case (cmd_code)
          `PFL_CMD_UV_LIMIT: uv_limit_q <= cmd_wdata;
          `PFL_CMD_UV_REACTION: uv_reaction_q <= cmd_wdata[7:0];
          `PFL_CMD_OC_LIMIT: oc_limit_q <= cmd_wdata;
          `PFL_CMD_UC_LIMIT: uc_limit_q <= cmd_wdata;
          `PFL_CMD_OT_LIMIT: ot_limit_q <= cmd_wdata;
          default: ;
        endcase
      end
      if (cmd_read) begin
        case (cmd_code)
          `PFL_CMD_UV_LIMIT: cmd_rdata_q <= uv_limit_q;
          `PFL_CMD_UV_REACTION: cmd_rdata_q <= {8'h00, uv_reaction_q};
          `PFL_CMD_OC_LIMIT: cmd_rdata_q <= oc_limit_q;
          `PFL_CMD_UC_LIMIT: cmd_rdata_q <= uc_limit_q;
          `PFL_CMD_OT_LIMIT: cmd_rdata_q <= ot_limit_q;
          default: cmd_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // Sticky fault flags; a new event in the clearing cycle keeps its flag
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_uv_q <= 1'b0;
      fault_oc_q <= 1'b0;
      fault_uc_q <= 1'b0;
      fault_ot_q <= 1'b0;
    end else begin
      fault_uv_q <= uv_ev || (fault_uv_q && !clear_faults);
      fault_oc_q <= oc_ev || (fault_oc_q && !clear_faults);
      fault_uc_q <= uc_ev || (fault_uc_q && !clear_faults);
      fault_ot_q <= ot_ev || (fault_ot_q && !clear_faults);
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      output_enable_q <= 1'b0;
      output_good_flag_q <= 1'b0;
      retries_q <= 3'h0;
      armed_q <= 1'b0;
    end else begin
      // Power good follows the same threshold as the fault; it drops together with the
      // stage so it never outlives an enable that is being switched off on this edge
      output_good_flag_q <= (state_q == ST_RUN) && output_enable_q && !vout_low &&
        !go_off && !shutdown_ev;
      if (clear_faults) begin
        armed_q <= 1'b0;
      end
      case (state_q)
        ST_OFF: begin
          output_enable_q <= 1'b0;
          armed_q <= 1'b0;
          if (!go_off && !shutdown_ev) begin
            state_q <= ST_RUN;
            output_enable_q <= 1'b1;
          end
        end
        ST_RUN: begin
          if (go_off) begin
            state_q <= ST_OFF;
            output_enable_q <= 1'b0;
          end else if (shutdown_ev) begin
            state_q <= ST_HOLD;
            output_enable_q <= 1'b0;
          end else if (uv_ev && uv_retry_mode) begin
            output_enable_q <= 1'b0;
            retries_q <= retries_now;
            armed_q <= 1'b1;
            if (retries_now == `PFL_RETRY_NONE) begin
              state_q <= ST_HOLD;
            end else begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          output_enable_q <= 1'b0;
          if (go_off) begin
            state_q <= ST_OFF;
          end else if (shutdown_ev) begin
            state_q <= ST_HOLD;
          end else if (tmr_done) begin
            state_q <= ST_RUN;
            output_enable_q <= 1'b1;
            // Endless setting never runs down
            if (retries_q != `PFL_RETRY_ENDLESS) begin
              retries_q <= retries_q - 3'h1;
            end
          end
        end
        ST_HOLD: begin
          output_enable_q <= 1'b0;
          // Stays dark until software clears the fault
          if (clear_faults) begin
            state_q <= ST_OFF;
          end
        end
        default: begin
          state_q <= ST_OFF;
          output_enable_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // pfl_fault_ctrl

`default_nettype wire

// [testbench/pfl_fault_ctrl_properties.sv]
// Port checks for the fault limit block
`include "pfl_consts.vh"
`default_nettype none
module pfl_fault_ctrl_properties #(
  parameter RETRY_UNIT_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rvalid_q,
  input wire logic cmd_unsupported_q,
  input wire logic clear_faults,
  input wire logic output_enable_q,
  input wire logic output_good_flag_q,
  input wire logic fault_uv_q,
  input wire logic fault_oc_q,
  input wire logic fault_uc_q,
  input wire logic fault_ot_q,
  input wire logic alert_line_out,
  input wire logic alert_line_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q;
  int off_q;
  wire any_f = fault_uv_q | fault_oc_q | fault_uc_q | fault_ot_q;
  wire known = cmd_code == `PFL_CMD_UV_LIMIT || cmd_code == `PFL_CMD_UV_REACTION ||
    cmd_code == `PFL_CMD_OC_LIMIT || cmd_code == `PFL_CMD_UC_LIMIT ||
    cmd_code == `PFL_CMD_OT_LIMIT;
  // Shadow of the reaction byte so mode checks need no internal probe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 8'h00;
      off_q <= 0;
    end else begin
      if (cmd_write && cmd_code == `PFL_CMD_UV_REACTION) rx_q <= cmd_wdata[7:0];
      off_q <= output_enable_q ? 0 : off_q + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (cmd_read |=> cmd_rvalid_q)
    else $error("read without answer");
  a_unknown_code: assert property ((cmd_read || cmd_write) && !known |=> cmd_unsupported_q)
    else $error("unknown code not flagged");
  a_alert_flags: assert property (alert_line_oe_n == !any_f)
    else $error("alert does not follow flags");
  a_alert_data: assert property (!alert_line_out)
    else $error("alert data not low");
  a_good_needs_on: assert property (output_good_flag_q |-> output_enable_q)
    else $error("good while stage off");
  a_mode_off: assert property ($rose(fault_uv_q) && rx_q[7:6] == 2'h2 |-> !output_enable_q)
    else $error("output kept on in mode 10");
  a_hold_stays: assert property (!clear_faults &&
    fault_uv_q && !output_enable_q && rx_q[7:3] == 5'h10 |=> !output_enable_q)
    else $error("restart with count zero");
  a_retry_wait: assert property ($rose(output_enable_q) && fault_uv_q && rx_q[7:6] == 2'h2 |->
    off_q >= (rx_q[2:0] + 1) * RETRY_UNIT_CYCLES)
    else $error("restart too early");
  a_oc_stops: assert property ($rose(fault_oc_q) |-> ##[0:2] !output_enable_q)
    else $error("output on after over-current");
endmodule // pfl_fault_ctrl_properties
bind pfl_fault_ctrl pfl_fault_ctrl_properties #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) chk_i (.*);
`default_nettype wire

// [testbench/pfl_host_model.sv]
// Host side of the command port: single-cycle writes and reads
`default_nettype none
module pfl_host_model (
  input wire logic clk_sys,
  input wire logic [15:0] cmd_rdata_q,
  input wire logic cmd_rvalid_q,
  output logic [7:0] cmd_code,
  output logic cmd_write,
  output logic cmd_read,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_code = 8'h00;
    cmd_write = 1'h0;
    cmd_read = 1'h0;
    cmd_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cmd_code = c;
    cmd_wdata = d;
    cmd_write = 1'h1;
    @(posedge clk_sys);
    #1;
    cmd_write = 1'h0;
    // Stale data would hide a write taken on the wrong edge
    cmd_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    cmd_code = c;
    cmd_read = 1'h1;
    @(posedge clk_sys);
    #1;
    cmd_read = 1'h0;
    d = cmd_rdata_q;
    v = cmd_rvalid_q;
  endtask
endmodule // pfl_host_model
`default_nettype wire

// [testbench/pfl_fault_ctrl_tb.sv]
// Self-checking bench for the fault limit block
`include "pfl_consts.vh"
`default_nettype none
module pfl_fault_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int U = 20;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] cmd_code;
  logic cmd_write, cmd_read, cmd_rvalid_q, cmd_unsupported_q;
  logic [15:0] cmd_wdata, cmd_rdata_q, vout_meas, iout_phase0_peak, iout_phase1_peak, temp_meas;
  logic output_on_cmd, bias_ok, clear_faults, output_enable_q, output_good_flag_q;
  logic fault_uv_q, fault_oc_q, fault_uc_q, fault_ot_q, alert_line_out, alert_line_oe_n;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  pfl_fault_ctrl #(.RETRY_UNIT_CYCLES(U)) uut (.*);
  pfl_host_model host (.*);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic setup(input logic [7:0] rx);
    output_on_cmd = 1'h0;
    vout_meas = 16'h2000;
    host.wr(`PFL_CMD_UV_LIMIT, 16'h1000);
    host.wr(`PFL_CMD_UV_REACTION, {8'h00, rx});
    host.wr(`PFL_CMD_OC_LIMIT, 16'h0040);
    host.wr(`PFL_CMD_UC_LIMIT, 16'h0008);
    host.wr(`PFL_CMD_OT_LIMIT, 16'h0050);
    clear_faults = 1'h1;
    cy(2);
    clear_faults = 1'h0;
    output_on_cmd = 1'h1;
    cy(3);
    chk("enable", output_enable_q, 1);
    chk("good", output_good_flag_q, 1);
    chk("alert", alert_line_oe_n, 1);
    chk("alert data", alert_line_out, 0);
  endtask
  task automatic t_regs;
    logic [7:0] c[5] = '{8'h44, 8'h45, 8'h46, 8'h4B, 8'h4F};
    logic [15:0] d;
    logic v;
    foreach (c[i]) begin
      host.rd(c[i], d, v);
      chk("reset value", d, 16'h0000);
      host.wr(c[i], 16'hA5C3);
      host.rd(c[i], d, v);
      chk("readback", d, c[i] == 8'h45 ? 16'h00C3 : 16'hA5C3);
      chk("rvalid", v, 1);
    end
    host.wr(8'h47, 16'h1234);
    chk("unsupported", cmd_unsupported_q, 1);
    host.rd(8'h47, d, v);
    chk("unknown read", d, 16'h0000);
  endtask
  task automatic t_retry_once;
    int n = 0;
    setup(8'h89);
    vout_meas = 16'h0800;
    cy(2);
    chk("uv flag", fault_uv_q, 1);
    chk("off", output_enable_q, 0);
    chk("alert low", alert_line_oe_n, 0);
    while (!output_enable_q && n < 10 * U) begin
      cy(1);
      n++;
    end
    chk("retry gap", n >= 2 * U - 2 && n <= 2 * U + 4, 1);
    cy(6 * U);
    chk("held off", output_enable_q, 0);
    vout_meas = 16'h2000;
    clear_faults = 1'h1;
    cy(1);
    clear_faults = 1'h0;
    cy(3);
    chk("restarted", output_enable_q, 1);
    chk("cleared", fault_uv_q, 0);
  endtask
  task automatic t_modes;
    logic [7:0] m[4] = '{8'h80, 8'h40, 8'h00, 8'hC0};
    foreach (m[i]) begin
      setup(m[i]);
      vout_meas = 16'h0800;
      cy(4 * U);
      chk("uv flag", fault_uv_q, 1);
      chk("alert low", alert_line_oe_n, 0);
      chk("mode enable", output_enable_q, m[i][7:6] != 2'h2);
      chk("good low", output_good_flag_q, 0);
    end
  endtask
  task automatic t_endless;
    int r = 0;
    logic p = 1'h1;
    setup(8'hB8);
    vout_meas = 16'h0800;
    repeat (12 * U) begin
      cy(1);
      if (output_enable_q && !p) r++;
      p = output_enable_q;
    end
    chk("endless", r >= 4, 1);
    bias_ok = 1'h0;
    cy(3 * U);
    chk("bias off", output_enable_q, 0);
    bias_ok = 1'h1;
  endtask
  task automatic t_limits;
    setup(8'h00);
    vout_meas = 16'hF000;
    cy(3);
    chk("unsigned uv", fault_uv_q, 0);
    iout_phase1_peak = 16'h0050;
    cy(3);
    chk("oc flag", fault_oc_q, 1);
    chk("oc off", output_enable_q, 0);
    iout_phase1_peak = 16'h0010;
    setup(8'h00);
    iout_phase0_peak = 16'h0004;
    cy(3);
    chk("uc flag", fault_uc_q, 1);
    iout_phase0_peak = 16'h0010;
    temp_meas = 16'h0060;
    cy(3);
    chk("ot flag", fault_ot_q, 1);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    output_on_cmd = 1'h0;
    bias_ok = 1'h1;
    clear_faults = 1'h0;
    vout_meas = 16'h0000;
    iout_phase0_peak = 16'h0010;
    iout_phase1_peak = 16'h0010;
    temp_meas = 16'h0020;
    cy(16);
    rst_n = 1'h1;
    t_regs();
    t_retry_once();
    t_modes();
    t_endless();
    t_limits();
    complete_run();
  end
endmodule // pfl_fault_ctrl_tb
`default_nettype wire
